// ===== design/lane_alarm_pkg.sv
// Constants shared by the lane alarm summary block: word offsets, field positions, reset values.
// Assumes a word-addressed Avalon-MM slave with 16-bit data in the low half of a 32-bit bus.
package lane_alarm_pkg;
	localparam int unsigned LANES = 16;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	// Word indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_GLOBAL_SUMMARY = 16'ha018;
	localparam logic [ADDR_W-1:0] IDX_NET_AW_SUMMARY = 16'ha019;
	localparam logic [ADDR_W-1:0] IDX_NET_FS_SUMMARY = 16'ha01a;
	localparam logic [ADDR_W-1:0] IDX_HOST_FS_SUMMARY = 16'ha01b;
	localparam logic [ADDR_W-1:0] IDX_RESERVED_WORD = 16'ha01c;
	localparam logic [ADDR_W-1:0] IDX_GENERAL_COND = 16'ha01d;
	localparam logic [ADDR_W-1:0] IDX_SOFT_CONTROL = 16'ha010;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 16'hb000;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 16'hb001;
	// Global summary fields
	localparam int unsigned GS_NET_FS_BIT = 13;
	localparam int unsigned GS_NET_AW_BIT = 12;
	localparam int unsigned GS_SOFT_TEST_BIT = 0;
	// Soft control field
	localparam int unsigned SC_GLOBAL_TEST_BIT = 9;
	// General condition fields
	localparam int unsigned GC_INTERLOCK_BIT = 13;
	localparam int unsigned GC_REFERENCE_CLOCK_INPUT_LOSS_BIT = 10;
	localparam int unsigned GC_JITTER_PLL_BIT = 9;
	localparam int unsigned GC_CMU_BIT = 8;
	// Interrupt status and mask fields
	localparam int unsigned IRQ_W = 6;
	localparam int unsigned IRQ_NET_AW = 0;
	localparam int unsigned IRQ_NET_FS = 1;
	localparam int unsigned IRQ_HOST_FS = 2;
	localparam int unsigned IRQ_INTERLOCK = 3;
	localparam int unsigned IRQ_REFERENCE_CLOCK_INPUT = 4;
	localparam int unsigned IRQ_PLL = 5;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLAVEERROR = 2'h2;
endpackage

// ===== design/pin_sync3.sv
// Three-stage synchroniser for asynchronous status pins, one per bit.
// Assumes inputs come from outside the clock domain; output flips when stages two and three agree.
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.s1 = i_async;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		for (int b = 0; b < WIDTH; b++) begin
			if (state_reg.s2[b] == state_reg.s3[b]) begin
				state_next.q[b] = state_reg.s3[b];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sync = state_reg.q;
endmodule

// ===== design/lane_reduce.sv
// Per-lane reduction: each summary bit is the OR of that lane's enabled latched bits.
// Assumes latch and enable vectors are already on the block's clock, lane n in slice n.
`timescale 1ns/10ps
module lane_reduce #(
	parameter int unsigned LANES = 16,
	parameter int unsigned BITS  = 16
) (
	input  wire logic [LANES*BITS-1:0] i_latch,
	input  wire logic [LANES*BITS-1:0] i_enable,
	output logic      [LANES-1:0]      o_summary
);
	genvar n;
	generate
		for (n = 0; n < LANES; n++) begin : g_lane
			assign o_summary[n] = |(i_latch[n*BITS +: BITS] & i_enable[n*BITS +: BITS]);
		end
	endgenerate
endmodule

// ===== design/lane_alarm_summary.sv
// Alarm summary words for network and host lanes plus the upper general condition bits.
// Assumes latch/enable vectors arrive on i_clk; the four condition pins are asynchronous.
`timescale 1ns/10ps

module lane_alarm_summary (
	input  wire logic                                 i_clk,
	input  wire logic                                 i_nrst,
	input  wire logic [lane_alarm_pkg::ADDR_W-1:0]    i_avs_address,
	input  wire logic                                 i_avs_read,
	input  wire logic                                 i_avs_write,
	input  wire logic [lane_alarm_pkg::DATA_W-1:0]    i_avs_writedata,
	input  wire logic [3:0]                           i_avs_byteenable,
	output logic      [lane_alarm_pkg::DATA_W-1:0]    o_avs_readdata,
	output logic                                      o_avs_waitrequest,
	output logic      [1:0]                           o_avs_response,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_net_aw_latch,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_net_aw_enable,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_net_fs_latch,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_net_fs_enable,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_host_fs_latch,
	input  wire logic [lane_alarm_pkg::LANES*16-1:0]  i_host_fs_enable,
	input  wire logic                                 i_cooling_interlock,
	input  wire logic                                 i_reference_clock_input_loss,
	input  wire logic                                 i_tx_jitter_pll_unlock,
	input  wire logic                                 i_tx_clock_mult_unlock,
	output logic                                      o_global_test,
	output logic                                      o_irq
);
	import lane_alarm_pkg::*;

	typedef enum logic [2:0] {
		BUS_IDLE   = 3'b001,
		BUS_ANSWER = 3'b010,
		BUS_DONE   = 3'b100
	} bus_state_t;

	typedef struct packed {
		bus_state_t       bus;
		logic [15:0]      net_aw;
		logic [15:0]      net_fs;
		logic [15:0]      host_fs;
		logic [15:0]      general;
		logic             soft_test;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [IRQ_W-1:0] prev_events;
		logic [DATA_W-1:0] rdata;
		logic              wait_req;
		logic [1:0]        resp;
		logic              irq;
	} blk_state_t;

	blk_state_t state_reg;
	blk_state_t state_next;

	logic [LANES-1:0] net_aw_comb;
	logic [LANES-1:0] net_fs_comb;
	logic [LANES-1:0] host_fs_comb;
	logic [3:0]       cond_sync;

	lane_reduce #(.LANES(LANES), .BITS(16)) u_net_aw (
		.i_latch   (i_net_aw_latch),
		.i_enable  (i_net_aw_enable),
		.o_summary (net_aw_comb)
	);

	lane_reduce #(.LANES(LANES), .BITS(16)) u_net_fs (
		.i_latch   (i_net_fs_latch),
		.i_enable  (i_net_fs_enable),
		.o_summary (net_fs_comb)
	);

	lane_reduce #(.LANES(LANES), .BITS(16)) u_host_fs (
		.i_latch   (i_host_fs_latch),
		.i_enable  (i_host_fs_enable),
		.o_summary (host_fs_comb)
	);

	// Condition pins come from other clock domains
	pin_sync3 #(.WIDTH(4)) u_cond_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async ({i_cooling_interlock, i_reference_clock_input_loss,
			i_tx_jitter_pll_unlock, i_tx_clock_mult_unlock}),
		.o_sync  (cond_sync)
	);

	function automatic logic [15:0] global_word(input blk_state_t s);
		logic [15:0] w;
		w = WORD_RESET;
		w[GS_NET_FS_BIT] = |s.net_fs;
		w[GS_NET_AW_BIT] = |s.net_aw;
		w[GS_SOFT_TEST_BIT] = s.soft_test;
		return w;
	endfunction

	always_comb begin
		logic [IRQ_W-1:0] events;
		logic [15:0]      rword;
		logic             hit;
		logic             wr;
		state_next = state_reg;
		events = '0;
		rword = WORD_RESET;
		hit = 1'b1;
		wr = 1'b0;

		// Summaries registered every cycle; one cycle of lag, no read effect
		state_next.net_aw = net_aw_comb;
		state_next.net_fs = net_fs_comb;
		state_next.host_fs = host_fs_comb;
		state_next.general = WORD_RESET;
		state_next.general[GC_INTERLOCK_BIT] = cond_sync[3];
		state_next.general[GC_REFERENCE_CLOCK_INPUT_LOSS_BIT] = cond_sync[2];
		state_next.general[GC_JITTER_PLL_BIT] = cond_sync[1];
		state_next.general[GC_CMU_BIT] = cond_sync[0];

		// Rising edges of the summarised conditions are interrupt events
		events[IRQ_NET_AW] = (|state_reg.net_aw) & ~state_reg.prev_events[IRQ_NET_AW];
		events[IRQ_NET_FS] = (|state_reg.net_fs) & ~state_reg.prev_events[IRQ_NET_FS];
		events[IRQ_HOST_FS] = (|state_reg.host_fs) & ~state_reg.prev_events[IRQ_HOST_FS];
		events[IRQ_INTERLOCK] = state_reg.general[GC_INTERLOCK_BIT]
			& ~state_reg.prev_events[IRQ_INTERLOCK];
		events[IRQ_REFERENCE_CLOCK_INPUT] = state_reg.general[GC_REFERENCE_CLOCK_INPUT_LOSS_BIT]
			& ~state_reg.prev_events[IRQ_REFERENCE_CLOCK_INPUT];
		events[IRQ_PLL] = (state_reg.general[GC_JITTER_PLL_BIT]
			| state_reg.general[GC_CMU_BIT]) & ~state_reg.prev_events[IRQ_PLL];
		state_next.prev_events = {
			state_reg.general[GC_JITTER_PLL_BIT] | state_reg.general[GC_CMU_BIT],
			state_reg.general[GC_REFERENCE_CLOCK_INPUT_LOSS_BIT],
			state_reg.general[GC_INTERLOCK_BIT],
			|state_reg.host_fs, |state_reg.net_fs, |state_reg.net_aw};

		// Register decode
		if (i_avs_address == IDX_GLOBAL_SUMMARY) begin
			rword = global_word(state_reg);
		end else if (i_avs_address == IDX_NET_AW_SUMMARY) begin
			rword = state_reg.net_aw;
		end else if (i_avs_address == IDX_NET_FS_SUMMARY) begin
			rword = state_reg.net_fs;
		end else if (i_avs_address == IDX_HOST_FS_SUMMARY) begin
			rword = state_reg.host_fs;
		end else if (i_avs_address == IDX_RESERVED_WORD) begin
			rword = WORD_RESET;
		end else if (i_avs_address == IDX_GENERAL_COND) begin
			rword = state_reg.general;
		end else if (i_avs_address == IDX_SOFT_CONTROL) begin
			rword[SC_GLOBAL_TEST_BIT] = state_reg.soft_test;
		end else if (i_avs_address == IDX_IRQ_STATUS) begin
			rword[IRQ_W-1:0] = state_reg.irq_status;
		end else if (i_avs_address == IDX_IRQ_MASK) begin
			rword[IRQ_W-1:0] = state_reg.irq_mask;
		end else begin
			hit = 1'b0;
		end

		// Sticky status; a set in the clearing cycle wins
		state_next.irq_status = state_reg.irq_status | events;

		case (state_reg.bus)
			BUS_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					state_next.bus = BUS_ANSWER;
					state_next.wait_req = 1'b0;
					state_next.resp = hit ? RESP_OKAY : RESP_SLAVEERROR;
					state_next.rdata = i_avs_read ? {16'h0000, rword} : '0;
				end
			end
			BUS_ANSWER: begin
				// Master sees waitrequest low at this edge, so the write lands only now
				state_next.bus = BUS_DONE;
				state_next.wait_req = 1'b1;
				wr = i_avs_write && hit;
			end
			BUS_DONE: begin
				// One quiet cycle so the master can release its request
				state_next.bus = BUS_IDLE;
			end
			default: begin
				state_next.bus = BUS_IDLE;
				state_next.wait_req = 1'b1;
			end
		endcase

		if (wr && i_avs_byteenable[1] && i_avs_address == IDX_SOFT_CONTROL) begin
			state_next.soft_test = i_avs_writedata[SC_GLOBAL_TEST_BIT];
		end
		if (wr && i_avs_byteenable[0] && i_avs_address == IDX_IRQ_MASK) begin
			state_next.irq_mask = i_avs_writedata[IRQ_W-1:0];
		end
		if (wr && i_avs_byteenable[0] && i_avs_address == IDX_IRQ_STATUS) begin
			state_next.irq_status = (state_reg.irq_status & ~i_avs_writedata[IRQ_W-1:0])
				| events;
		end

		state_next.irq = |(state_next.irq_status & state_next.irq_mask);
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_reg.bus <= BUS_IDLE;
			state_reg.net_aw <= WORD_RESET;
			state_reg.net_fs <= WORD_RESET;
			state_reg.host_fs <= WORD_RESET;
			state_reg.general <= WORD_RESET;
			state_reg.soft_test <= 1'b0;
			state_reg.irq_status <= IRQ_RESET;
			state_reg.irq_mask <= IRQ_RESET;
			state_reg.prev_events <= IRQ_RESET;
			state_reg.rdata <= '0;
			state_reg.wait_req <= 1'b1;
			state_reg.resp <= RESP_OKAY;
			state_reg.irq <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Waitrequest high except in the answer cycle
	assign o_avs_waitrequest = state_reg.wait_req;
	assign o_avs_readdata = state_reg.rdata;
	assign o_avs_response = state_reg.resp;
	assign o_global_test = state_reg.soft_test;
	assign o_irq = state_reg.irq;
endmodule

// ===== dv/lane_alarm_summary_properties.sv
// Checker for the register port of the lane alarm summary block.
// Assumes it is bound to lane_alarm_summary and sees only its ports.
`timescale 1ns/10ps
module lane_alarm_summary_checker
	import lane_alarm_pkg::*;
(
	input wire logic                              i_clk,
	input wire logic                              i_nrst,
	input wire logic [lane_alarm_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic                              i_avs_read,
	input wire logic                              i_avs_write,
	input wire logic [lane_alarm_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [lane_alarm_pkg::DATA_W-1:0] o_avs_readdata,
	input wire logic                              o_avs_waitrequest,
	input wire logic [1:0]                        o_avs_response,
	input wire logic                              o_global_test,
	input wire logic                              o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic done_rd;
	logic mapped;
	assign done_rd = i_avs_read && !o_avs_waitrequest;
	assign mapped = i_avs_address inside {IDX_SOFT_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_MASK,
		[IDX_GLOBAL_SUMMARY:IDX_GENERAL_COND]};
	reset_values_a: assert property ($rose(i_nrst) |-> o_avs_waitrequest && !o_irq
		&& !o_global_test && o_avs_readdata == 32'h0) else $error("outputs not at reset value");
	wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	answer_time_a: assert property ($rose(i_avs_read) || $rose(i_avs_write) |=> !o_avs_waitrequest)
		else $error("no answer one cycle after request");
	test_mirror_a: assert property (done_rd && i_avs_address == IDX_GLOBAL_SUMMARY |->
		o_avs_readdata[GS_SOFT_TEST_BIT] == o_global_test) else $error("test bit mismatch");
	upper_zero_a: assert property (done_rd |-> o_avs_readdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	unmapped_err_a: assert property (done_rd && !mapped |->
		o_avs_response == RESP_SLAVEERROR && o_avs_readdata == 32'h0) else $error("bad unmapped");
	mapped_ok_a: assert property (done_rd && mapped |-> o_avs_response == RESP_OKAY)
		else $error("mapped read not okay");
	read_quiet_a: assert property (i_avs_read |=> $stable(o_global_test))
		else $error("read changed test bit");
	mask_off_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_address == IDX_IRQ_MASK
		&& i_avs_writedata[IRQ_W-1:0] == 6'h00 |=> !o_irq) else $error("masked irq high");
endmodule

bind lane_alarm_summary lane_alarm_summary_checker u_chk (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_avs_response(o_avs_response), .o_global_test(o_global_test), .o_irq(o_irq)
);

// ===== dv/avalon_host_model.sv
// Host management controller model: Avalon-MM master, one access at a time.
// Assumes a slave that answers by dropping waitrequest; no timeout of its own.
`timescale 1ns/10ps
module avalon_host_model (
	input  wire logic        i_clk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	input  wire logic [1:0]  i_response,
	output logic      [15:0] o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata
);
	initial {o_address, o_read, o_write, o_writedata} = '0;
	task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic [1:0] resp);
		@(posedge i_clk);
		o_address <= a;
		o_writedata <= wd;
		o_read <= !we;
		o_write <= we;
		do @(posedge i_clk); while (i_waitrequest !== 1'b0);
		rd = i_readdata;
		resp = i_response;
		o_read <= 1'b0;
		o_write <= 1'b0;
		// Released lines must not look valid
		o_address <= ~a;
		o_writedata <= ~wd;
		@(posedge i_clk);
	endtask
endmodule

// ===== dv/lane_alarm_summary_test.sv
// Self-checking bench for the lane alarm summary block.
// Assumes the host model issues accesses; latches, enables and pins are driven here.
`timescale 1ns/10ps
module lane_alarm_summary_test;
	import lane_alarm_pkg::*;
	logic         i_clk, i_nrst, rd, wr, wq, irq, gtest;
	logic [255:0] aw_l, aw_e, fs_l, fs_e, hs_l, hs_e;
	logic [31:0]  wdata, rdata, d;
	logic [15:0]  addr;
	logic [15:0]  gc[4] = '{16'h2000, 16'h0400, 16'h0200, 16'h0100};
	logic [3:0]   pins;
	logic [1:0]   resp, r;
	int           num_errors = 0;
	int           cmp_count = 0;
	lane_alarm_summary u_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wq), .o_avs_response(resp),
		.i_net_aw_latch(aw_l), .i_net_aw_enable(aw_e), .i_net_fs_latch(fs_l),
		.i_net_fs_enable(fs_e), .i_host_fs_latch(hs_l), .i_host_fs_enable(hs_e),
		.i_cooling_interlock(pins[3]), .i_reference_clock_input_loss(pins[2]),
		.i_tx_jitter_pll_unlock(pins[1]), .i_tx_clock_mult_unlock(pins[0]),
		.o_global_test(gtest), .o_irq(irq)
	);
	avalon_host_model u_host (
		.i_clk(i_clk), .i_waitrequest(wq), .i_readdata(rdata), .i_response(resp),
		.o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdata)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, d, r);
		chk(d, exp);
	endtask
	task automatic wr32(input logic [15:0] a, input logic [31:0] v);
		u_host.xfer(1'b1, a, v, d, r);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		repeat (4000) @(posedge i_clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		i_nrst = 1'b0;
		{aw_l, fs_l, hs_l} = '1;
		{aw_e, fs_e, hs_e} = '0;
		pins = 4'h0;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		// Latches all set but nothing enabled: every word must stay clear
		for (logic [15:0] a = IDX_GLOBAL_SUMMARY; a <= IDX_GENERAL_COND; a++) rdchk(a, 32'h0);
		u_host.xfer(1'b0, 16'h0123, 32'h0, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLAVEERROR});
		chk(d, 32'h0);
		wr32(IDX_NET_AW_SUMMARY, 32'hffff);
		rdchk(IDX_NET_AW_SUMMARY, 32'h0);
		wr32(IDX_SOFT_CONTROL, 32'h1 << SC_GLOBAL_TEST_BIT);
		chk({31'h0, gtest}, 32'h1);
		rdchk(IDX_SOFT_CONTROL, 32'h1 << SC_GLOBAL_TEST_BIT);
		rdchk(IDX_GLOBAL_SUMMARY, 32'h1);
		wr32(IDX_SOFT_CONTROL, 32'h0);
		rdchk(IDX_GLOBAL_SUMMARY, 32'h0);
		for (int n = 0; n < 16; n++) begin
			@(posedge i_clk);
			aw_e <= 256'h1 << (16 * n + 15 - n);
			fs_e <= 256'h1 << (16 * n + n);
			hs_e <= 256'h1 << (16 * (15 - n) + n);
			rdchk(IDX_NET_AW_SUMMARY, 32'h1 << n);
			rdchk(IDX_NET_FS_SUMMARY, 32'h1 << n);
			rdchk(IDX_HOST_FS_SUMMARY, 32'h1 << (15 - n));
			rdchk(IDX_GLOBAL_SUMMARY, 32'h3000);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			pins <= 4'h8 >> k;
			repeat (8) @(posedge i_clk);
			rdchk(IDX_GENERAL_COND, {16'h0, gc[k]});
		end
		rdchk(IDX_IRQ_STATUS, 32'h3f);
		wr32(IDX_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr32(IDX_IRQ_STATUS, 32'h3f);
		chk({31'h0, irq}, 32'h0);
		rdchk(IDX_IRQ_STATUS, 32'h0);
		@(posedge i_clk);
		aw_e <= '0;
		repeat (3) @(posedge i_clk);
		rdchk(IDX_GLOBAL_SUMMARY, 32'h2000);
		aw_e <= '1;
		repeat (5) @(posedge i_clk);
		chk({31'h0, irq}, 32'h1);
		wr32(IDX_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		tally_and_finish();
	end
endmodule
